/* rkh_defs.svh */
// Constants of the root key hash write handler: frame bytes, field indices,
// status codes and policy masks. Included by the package only.
// Functional notes
// - Success reply: 81h,00h,0Ah,2Eh,status 00h, details and address unused code.
// - Failure reply: same length, response AEh, status, four-byte details and address.
// - Command frame starts at command start byte; other bytes are skipped.
// - Command frame without frame end byte gives a packet error.
// - Command frame checksum mismatch gives a checksum error.
// - Command length wrong for format or for this command gives packet error.
// - Any reported check error abandons the command, memory untouched, back to waiting.
// - Lifecycle state not permitting the command gives acceptance error.
// - Encrypted write without later reset gives acceptance error.
// - Authentication level zero or one gives a secure error.
// - Unsupported key identifier or lock field value gives parameter error.
// - Selected hash slot already permanently locked gives protection error.
// - All command checks passed: OK reply is sent before key data frames.
// - Data frame starts at data start byte; other bytes are discarded.
// - Data frame: missing end, bad length, bad response code, bad checksum errors.
// - Key data beyond the declared amount gives a parameter error.
// - Security subsystem abnormal after hashing: no reply, memory unchanged.
// - Hash generation failure gives trusted system error, back to waiting.
// - Write failure: flash access error, details carry flash status.
// - Write success: OK reply; lock also set when lock field is 00h.
// - Several errors: highest priority one is reported, in the documented order.
`ifndef RKH_DEFS_SVH
`define RKH_DEFS_SVH

// Frame framing bytes, response and command codes, reply length, unused code
`define RKH_CMD_START   8'h01
`define RKH_DATA_START  8'h81
`define RKH_FRAME_END   8'h03
`define RKH_RSP_OK      8'h2E
`define RKH_RSP_ERR     8'hAE
`define RKH_CMD_CODE    8'h28
`define RKH_REPLY_LEN   8'h0A
`define RKH_UNUSED      32'h0FFFFFFF

// Frame lengths (payload bytes between length and checksum)
`define RKH_CMD_LEN     16'h0005
`define RKH_MAX_LEN     16'h0401

// Command payload indices, then the data frame response index
`define RKH_IDX_CMD     16'h0000
`define RKH_IDX_KID     16'h0001
`define RKH_IDX_PLK     16'h0002
`define RKH_IDX_SZH     16'h0003
`define RKH_IDX_SZL     16'h0004
`define RKH_IDX_RES     16'h0000

// Reply byte positions
`define RKH_TX_SUM_FIRST 4'h1
`define RKH_TX_SUM_LAST  4'hC
`define RKH_TX_LAST      4'hE

// Status codes
`define RKH_STS_OK       8'h00
`define RKH_STS_PACKET   8'hC1
`define RKH_STS_CHECKSUM 8'hC2
`define RKH_STS_ACCEPT   8'hC3
`define RKH_STS_PARAM    8'hC5
`define RKH_STS_SECURE   8'hDA
`define RKH_STS_PROTECT  8'hDB
`define RKH_STS_TRUSTED  8'hE4
`define RKH_STS_FLASH    8'hE1

// Policy: key identifiers, lock field values, lifecycle and level limits
`define RKH_KID_MAX      8'h03
`define RKH_PLK_LOCK     8'h00
`define RKH_PLK_KEEP     8'hFF
`define RKH_DLM_PERMIT   16'h0006
`define RKH_AUTH_LOW_TOP 2'h1

`endif

/* rkh_pkg.sv */
// Types shared by the frame receiver, reply sender and command handler.
// Assumes rkh_defs.svh sits in the include path.
`include "rkh_defs.svh"

package rkh_pkg;

  typedef enum logic [1:0] {
    RKH_FR_OK       = 2'h0,
    RKH_FR_PACKET   = 2'h1,
    RKH_FR_CHECKSUM = 2'h3
  } rkh_frerr_type;

  typedef enum logic [2:0] {
    RX_HUNT = 3'h0, RX_LNH = 3'h1, RX_LNL = 3'h3, RX_BODY = 3'h2, RX_SUM = 3'h6, RX_END = 3'h7
  } rkh_rxst_type;

  typedef enum logic [2:0] {
    ST_CMD = 3'h0, ST_REPLY = 3'h1, ST_DATA = 3'h3, ST_HASH = 3'h2, ST_FLASH = 3'h6
  } rkh_st_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] idx;
    logic [7:0]  data;
  } rkh_pay_type;

  typedef struct packed {
    logic          done;
    rkh_frerr_type err;
    logic [15:0]   len;
  } rkh_fdone_type;

  typedef struct packed {
    logic [7:0]  res;
    logic [7:0]  sts;
    logic [31:0] det;
    logic [31:0] adr;
  } rkh_reply_type;

  // Shared checksum step; a frame is good when the running sum ends at zero
  function automatic logic [7:0] rkh_sum_add(input logic [7:0] acc, input logic [7:0] b);
    return 8'(acc + b);
  endfunction

endpackage

/* rkh_frame_rx.sv */
// Frame receiver: hunts a start byte, reads length, payload, checksum, end.
// Assumes a byte stream on the same clock, one byte per valid cycle.
`timescale 1ns/1ps

module rkh_frame_rx
  import rkh_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          en,
  input  wire logic [7:0]    start_byte,
  input  wire logic          in_valid,
  input  wire logic [7:0]    in_data,
  output rkh_pay_type        pay,
  output rkh_fdone_type      fdone
);

  typedef struct packed {
    rkh_rxst_type  st;
    logic [15:0]   len;
    logic [15:0]   cnt;
    logic [7:0]    acc;
    logic          sum_ok;
    rkh_pay_type   pay;
    rkh_fdone_type fdone;
  } rkh_rx_state_type;

  rkh_rx_state_type q, d;

  // Parse one byte per valid cycle; errors are judged only at the end byte
  always_comb begin
    d = q;
    d.pay.valid = 1'b0;
    d.fdone.done = 1'b0;
    if (!en) begin
      d.st = RX_HUNT;
    end else if (in_valid) begin
      case (q.st)
        RX_HUNT: begin
          if (in_data == start_byte) begin
            d.st = RX_LNH;
            d.acc = 8'h00;
          end
        end
        RX_LNH: begin
          d.len[15:8] = in_data;
          d.acc = rkh_sum_add(q.acc, in_data);
          d.st = RX_LNL;
        end
        RX_LNL: begin
          d.len[7:0] = in_data;
          d.acc = rkh_sum_add(q.acc, in_data);
          d.cnt = 16'h0000;
          d.st = ({q.len[15:8], in_data} == 16'h0000) ? RX_SUM : RX_BODY;
        end
        RX_BODY: begin
          d.pay.valid = 1'b1;
          d.pay.idx = q.cnt;
          d.pay.data = in_data;
          d.acc = rkh_sum_add(q.acc, in_data);
          d.cnt = 16'(q.cnt + 16'h0001);
          if (16'(q.cnt + 16'h0001) == q.len) begin
            d.st = RX_SUM;
          end
        end
        RX_SUM: begin
          d.sum_ok = (rkh_sum_add(q.acc, in_data) == 8'h00);
          d.st = RX_END;
        end
        default: begin
          // Missing end beats checksum beats length format
          d.fdone.done = 1'b1;
          d.fdone.len = q.len;
          if (in_data != `RKH_FRAME_END) begin
            d.fdone.err = RKH_FR_PACKET;
          end else if (!q.sum_ok) begin
            d.fdone.err = RKH_FR_CHECKSUM;
          end else if (q.len == 16'h0000 || q.len > `RKH_MAX_LEN) begin
            d.fdone.err = RKH_FR_PACKET;
          end else begin
            d.fdone.err = RKH_FR_OK;
          end
          d.st = RX_HUNT;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pay = q.pay;
  assign fdone = q.fdone;

  end_missing_a: assert property (@(posedge clk) disable iff (!rst_n)
    en && in_valid && q.st == RX_END && in_data != `RKH_FRAME_END
    |=> fdone.done && fdone.err == RKH_FR_PACKET)
    else $error("missing end byte not reported as packet error");

endmodule

/* rkh_reply_tx.sv */
// Reply sender: emits one fifteen-byte status frame with its checksum.
// Assumes the sink takes a byte in any cycle where valid and ready are high.
`timescale 1ns/1ps

module rkh_reply_tx
  import rkh_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          go,
  input  rkh_reply_type      rep,
  input  wire logic          ready,
  output logic               valid,
  output logic [7:0]         data,
  output logic               done
);

  typedef struct packed {
    rkh_reply_type rep;
    logic [3:0]    idx;
    logic [7:0]    acc;
    logic          valid;
    logic [7:0]    data;
    logic          done;
  } rkh_tx_state_type;

  rkh_tx_state_type q, d;
  logic [7:0]       acc_n;

  // Byte at a reply position; fields go most significant byte first
  function automatic logic [7:0] byte_at(input logic [3:0] i, input rkh_reply_type r,
                                         input logic [7:0] acc);
    case (i)
      4'h0:    return `RKH_DATA_START;
      4'h1:    return 8'h00;
      4'h2:    return `RKH_REPLY_LEN;
      4'h3:    return r.res;
      4'h4:    return r.sts;
      4'h5:    return r.det[31:24];
      4'h6:    return r.det[23:16];
      4'h7:    return r.det[15:8];
      4'h8:    return r.det[7:0];
      4'h9:    return r.adr[31:24];
      4'hA:    return r.adr[23:16];
      4'hB:    return r.adr[15:8];
      4'hC:    return r.adr[7:0];
      4'hD:    return 8'(8'h00 - acc);
      default: return `RKH_FRAME_END;
    endcase
  endfunction

  // Advance one byte per accepted handshake; a new request is taken only while idle
  always_comb begin
    d = q;
    d.done = 1'b0;
    acc_n = q.acc;
    if (q.idx >= `RKH_TX_SUM_FIRST && q.idx <= `RKH_TX_SUM_LAST) begin
      acc_n = rkh_sum_add(q.acc, q.data);
    end
    if (q.valid) begin
      if (ready) begin
        d.acc = acc_n;
        if (q.idx == `RKH_TX_LAST) begin
          d.valid = 1'b0;
          d.done = 1'b1;
        end else begin
          d.idx = 4'(q.idx + 4'h1);
          d.data = byte_at(4'(q.idx + 4'h1), q.rep, acc_n);
        end
      end
    end else if (go) begin
      d.rep = rep;
      d.idx = 4'h0;
      d.acc = 8'h00;
      d.valid = 1'b1;
      d.data = `RKH_DATA_START;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign valid = q.valid;
  assign data = q.data;
  assign done = q.done;

  reply_head_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(valid) |-> data == `RKH_DATA_START)
    else $error("reply does not open with data start byte");

endmodule

/* rkh_handler.sv */
// Root key hash write command handler: checks the command frame, answers,
// collects key data, drives hash generation and the flash write, replies.
// Assumes byte streams, policy inputs and engine handshakes share REF_CLK.
`timescale 1ns/1ps

module rkh_handler
  import rkh_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        TX_READY,
  input  wire logic [3:0]  LIFECYCLE_STATE,
  input  wire logic        ENC_WRITE_PENDING,
  input  wire logic [1:0]  AUTH_LEVEL,
  input  wire logic [3:0]  LOCK_STATUS,
  input  wire logic        HASH_DONE,
  input  wire logic        HASH_FAIL,
  input  wire logic        TSS_ABNORMAL,
  input  wire logic        FLASH_DONE,
  input  wire logic        FLASH_FAIL,
  input  wire logic [31:0] FLASH_STATUS,
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  output logic             KEY_VALID,
  output logic [7:0]       KEY_DATA,
  output logic             KEY_CLEAR,
  output logic             HASH_START,
  output logic             FLASH_WRITE,
  output logic             FLASH_LOCK,
  output logic [1:0]       FLASH_KEY_ID
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    rkh_st_type    st;
    logic          after_ok;
    logic [7:0]    cmd;
    logic [7:0]    key_identifier;
    logic [7:0]    permanent_lock_field;
    logic [15:0]   size;
    logic [15:0]   got;
    logic [7:0]    res;
    logic          over;
    logic          rep_go;
    rkh_reply_type rep;
    logic          key_valid;
    logic [7:0]    key_data;
    logic          key_clear;
    logic          hash_start;
    logic          flash_write;
    logic          flash_lock;
    logic [1:0]    flash_kid;
  } rkh_main_state_type;

  localparam logic [15:0] DLM_PERMIT = `RKH_DLM_PERMIT;

  rkh_main_state_type q, d;
  rkh_pay_type        pay;
  rkh_fdone_type      fdone;
  logic               rx_en;
  logic [7:0]         rx_start;
  logic               tx_done;

  ////////////////////////////////////////////////////////////////////////////
  // Frame receiver and reply sender

  // Bytes arriving while a reply is in flight are dropped on purpose
  assign rx_en = (q.st == ST_CMD) || (q.st == ST_DATA);
  assign rx_start = (q.st == ST_DATA) ? `RKH_DATA_START : `RKH_CMD_START;

  rkh_frame_rx u_rx (
    .clk        (REF_CLK),
    .rst_n      (NRST),
    .en         (rx_en),
    .start_byte (rx_start),
    .in_valid   (RX_VALID),
    .in_data    (RX_DATA),
    .pay        (pay),
    .fdone      (fdone)
  );

  rkh_reply_tx u_tx (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .go    (q.rep_go),
    .rep   (q.rep),
    .ready (TX_READY),
    .valid (TX_VALID),
    .data  (TX_DATA),
    .done  (tx_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing

  // One process decides the reply; checks run in falling priority order
  always_comb begin
    logic       fire_v;
    logic       ok_v;
    logic       ack_v;
    logic [7:0] sts_v;
    logic [31:0] det_v;
    fire_v = 1'b0;
    ok_v = 1'b0;
    ack_v = 1'b0;
    sts_v = `RKH_STS_OK;
    det_v = `RKH_UNUSED;
    d = q;
    d.rep_go = 1'b0;
    d.key_valid = 1'b0;
    d.key_clear = 1'b0;
    d.hash_start = 1'b0;
    d.flash_write = 1'b0;
    case (q.st)
      ST_CMD: begin
        // Capture parameters as the payload streams past
        if (pay.valid) begin
          if (pay.idx == `RKH_IDX_CMD) begin
            d.cmd = pay.data;
          end else if (pay.idx == `RKH_IDX_KID) begin
            d.key_identifier = pay.data;
          end else if (pay.idx == `RKH_IDX_PLK) begin
            d.permanent_lock_field = pay.data;
          end else if (pay.idx == `RKH_IDX_SZH) begin
            d.size[15:8] = pay.data;
          end else if (pay.idx == `RKH_IDX_SZL) begin
            d.size[7:0] = pay.data;
          end
        end
        if (fdone.done) begin
          fire_v = 1'b1;
          if (fdone.err == RKH_FR_PACKET) begin
            sts_v = `RKH_STS_PACKET;
          end else if (fdone.err == RKH_FR_CHECKSUM) begin
            sts_v = `RKH_STS_CHECKSUM;
          end else if (q.cmd != `RKH_CMD_CODE) begin
            fire_v = 1'b0; // Another command: left to its own handler
          end else if (fdone.len != `RKH_CMD_LEN) begin
            sts_v = `RKH_STS_PACKET;
          end else if (!DLM_PERMIT[LIFECYCLE_STATE]) begin
            sts_v = `RKH_STS_ACCEPT;
          end else if (ENC_WRITE_PENDING) begin
            sts_v = `RKH_STS_ACCEPT;
          end else if (AUTH_LEVEL <= `RKH_AUTH_LOW_TOP) begin
            sts_v = `RKH_STS_SECURE;
          end else if (q.key_identifier > `RKH_KID_MAX) begin
            sts_v = `RKH_STS_PARAM;
          end else if (q.permanent_lock_field != `RKH_PLK_LOCK && q.permanent_lock_field != `RKH_PLK_KEEP) begin
            sts_v = `RKH_STS_PARAM;
          end else if (q.size == 16'h0000) begin
            sts_v = `RKH_STS_PARAM;
          end else if (LOCK_STATUS[q.key_identifier[1:0]]) begin
            sts_v = `RKH_STS_PROTECT;
          end else begin
            // All checks passed: acknowledge, then wait for key data
            ok_v = 1'b1;
            ack_v = 1'b1;
            d.key_clear = 1'b1;
            d.got = 16'h0000;
            d.over = 1'b0;
          end
        end
      end
      ST_DATA: begin
        // Only bytes within the declared amount reach the hash engine
        if (pay.valid) begin
          if (pay.idx == `RKH_IDX_RES) begin
            d.res = pay.data;
          end else if (q.got < q.size) begin
            d.key_valid = 1'b1;
            d.key_data = pay.data;
            d.got = 16'(q.got + 16'h0001);
          end else begin
            d.over = 1'b1;
          end
        end
        if (fdone.done) begin
          if (fdone.err == RKH_FR_PACKET) begin
            fire_v = 1'b1;
            sts_v = `RKH_STS_PACKET;
          end else if (fdone.err == RKH_FR_CHECKSUM) begin
            fire_v = 1'b1;
            sts_v = `RKH_STS_CHECKSUM;
          end else if (q.res != `RKH_RSP_OK) begin
            fire_v = 1'b1;
            sts_v = `RKH_STS_PACKET;
          end else if (q.over) begin
            fire_v = 1'b1;
            sts_v = `RKH_STS_PARAM;
          end else if (q.got == q.size) begin
            d.hash_start = 1'b1;
            d.st = ST_HASH;
          end
        end
      end
      ST_HASH: begin
        if (HASH_DONE) begin
          if (HASH_FAIL) begin
            fire_v = 1'b1;
            sts_v = `RKH_STS_TRUSTED;
          end else if (TSS_ABNORMAL) begin
            d.st = ST_CMD;
          end else begin
            // Lock only rides along when the lock field asks for it
            d.flash_write = 1'b1;
            d.flash_lock = (q.permanent_lock_field == `RKH_PLK_LOCK);
            d.flash_kid = q.key_identifier[1:0];
            d.st = ST_FLASH;
          end
        end
      end
      ST_FLASH: begin
        if (FLASH_DONE) begin
          fire_v = 1'b1;
          if (FLASH_FAIL) begin
            sts_v = `RKH_STS_FLASH;
            det_v = FLASH_STATUS;
          end else begin
            ok_v = 1'b1;
          end
        end
      end
      default: begin
        // Reply in flight; the next phase begins once its last byte leaves
        if (tx_done) begin
          d.st = q.after_ok ? ST_DATA : ST_CMD;
        end
      end
    endcase
    // Any reply: errors end the command and nothing is written
    if (fire_v) begin
      d.rep_go = 1'b1;
      d.rep.res = ok_v ? `RKH_RSP_OK : `RKH_RSP_ERR;
      d.rep.sts = sts_v;
      d.rep.det = det_v;
      d.rep.adr = `RKH_UNUSED;
      d.after_ok = ack_v;
      d.st = ST_REPLY;
    end
  end

  // State register
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // All straight from the state register
  assign KEY_VALID = q.key_valid;
  assign KEY_DATA = q.key_data;
  assign KEY_CLEAR = q.key_clear;
  assign HASH_START = q.hash_start;
  assign FLASH_WRITE = q.flash_write;
  assign FLASH_LOCK = q.flash_lock;
  assign FLASH_KEY_ID = q.flash_kid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking main_cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  ok_reply_shape_a: assert property (
    q.rep_go && q.rep.res == `RKH_RSP_OK
    |-> q.rep.sts == `RKH_STS_OK && q.rep.det == `RKH_UNUSED && q.rep.adr == `RKH_UNUSED)
    else $error("OK reply carries wrong status fields");

  err_reply_code_a: assert property (
    q.rep_go && q.rep.sts != `RKH_STS_OK |-> q.rep.res == `RKH_RSP_ERR)
    else $error("error status without error response code");

  ack_before_data_a: assert property (
    $rose(q.st == ST_DATA) |-> $past(q.st) == ST_REPLY && $past(tx_done) && q.rep.res == `RKH_RSP_OK)
    else $error("data phase entered without OK reply");

  cmd_err_nowrite_a: assert property (
    q.st == ST_CMD && fdone.done && fdone.err != RKH_FR_OK |=> !q.flash_write [*8])
    else $error("flash write after a framing error");

  secure_level_a: assert property (
    q.st == ST_CMD && fdone.done && fdone.err == RKH_FR_OK && q.cmd == `RKH_CMD_CODE
    && fdone.len == `RKH_CMD_LEN && DLM_PERMIT[LIFECYCLE_STATE] && !ENC_WRITE_PENDING
    && AUTH_LEVEL <= `RKH_AUTH_LOW_TOP
    |=> q.rep_go && q.rep.sts == `RKH_STS_SECURE)
    else $error("low authentication level not refused");

  silent_abnormal_a: assert property (
    q.st == ST_HASH && HASH_DONE && !HASH_FAIL && TSS_ABNORMAL
    |=> q.st == ST_CMD && !q.rep_go && !q.flash_write)
    else $error("abnormal subsystem produced a reply or write");

  flash_fail_det_a: assert property (
    q.st == ST_FLASH && FLASH_DONE && FLASH_FAIL
    |=> q.rep_go && q.rep.sts == `RKH_STS_FLASH && q.rep.det == $past(FLASH_STATUS))
    else $error("flash failure reply lacks flash status");

  key_bound_a: assert property (
    q.key_valid |-> q.got <= q.size && q.st == ST_DATA)
    else $error("more key bytes passed than declared");

  hash_fail_err_a: assert property (
    q.st == ST_HASH && HASH_DONE && HASH_FAIL
    |=> q.rep_go && q.rep.sts == `RKH_STS_TRUSTED ##1 !q.flash_write)
    else $error("hash failure not reported");

  ok_ack_cov: cover property (q.rep_go && q.after_ok);
  hash_go_cov: cover property (q.hash_start);
  write_ok_cov: cover property (q.st == ST_FLASH && FLASH_DONE && !FLASH_FAIL);
  abn_cov: cover property (q.st == ST_HASH && HASH_DONE && TSS_ABNORMAL);

endmodule

/* rkh_host_model.sv */
// Host tool model: frames bytes into the handler and sinks its replies.
// Assumes the handler's clock; drives its lines on falling edges.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module rkh_host_model
(
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data
);
  logic [7:0] rq[$];
  logic       slow = 1'b0;

  // Idle lines at time zero; a slow sink is ready only every other cycle
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
  end
  always @(negedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // Reply bytes in arrival order, taken on valid and ready
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      rq.push_back(tx_data);
    end
  end

  // One byte a cycle, MSB first; the line flips after release, never stale
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data  = f[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask
endmodule

/* rkh_handler_test.sv */
// Testbench of the key hash write handler: error table, then full writes.
// Assumes the host model; hash and flash engines are modelled here.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module rkh_handler_test;
  localparam logic [31:0] NO_INFO = 32'h0FFFFFFF;
  // Nibbles: bad kind, lifecycle, enc, auth, lock; bytes: kid, plk, status
  localparam logic [43:0] ERR_TAB [12] = '{
    44'h1102002FFC2,
    44'h2102002FFC1,
    44'h3102002FFC1,
    44'h0002002FFC3,
    44'h0112002FFC3,
    44'h0101002FFDA,
    44'h0100004FFDA,
    44'h0102004FFC5,
    44'h010200205C5,
    44'h0102402FFDB,
    44'h1000002FFC2,
    44'h0010004FFC3
  };
  logic        REF_CLK = 1'b0;
  logic        NRST, RX_VALID, TX_READY, ENC_WRITE_PENDING, HASH_DONE, HASH_FAIL;
  logic        TSS_ABNORMAL, FLASH_DONE, FLASH_FAIL, TX_VALID, KEY_VALID, KEY_CLEAR;
  logic        HASH_START, FLASH_WRITE, FLASH_LOCK;
  logic [7:0]  RX_DATA, TX_DATA, KEY_DATA;
  logic [3:0]  LIFECYCLE_STATE, LOCK_STATUS;
  logic [1:0]  AUTH_LEVEL, FLASH_KEY_ID;
  logic [31:0] FLASH_STATUS;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          keys = 0;
  int          writes = 0;
  int          clr = 0;
  logic [7:0]  kd = 8'h00;

  always #2.5 REF_CLK = ~REF_CLK;

  rkh_handler rkh_handler_i (
    .REF_CLK, .NRST, .RX_VALID, .RX_DATA, .TX_READY, .LIFECYCLE_STATE,
    .ENC_WRITE_PENDING, .AUTH_LEVEL, .LOCK_STATUS, .HASH_DONE, .HASH_FAIL,
    .TSS_ABNORMAL, .FLASH_DONE, .FLASH_FAIL, .FLASH_STATUS, .TX_VALID,
    .TX_DATA, .KEY_VALID, .KEY_DATA, .KEY_CLEAR, .HASH_START, .FLASH_WRITE,
    .FLASH_LOCK, .FLASH_KEY_ID
  );
  rkh_host_model rkh_host_model_i (
    .clk(REF_CLK), .rx_valid(RX_VALID), .rx_data(RX_DATA),
    .tx_ready(TX_READY), .tx_valid(TX_VALID), .tx_data(TX_DATA)
  );

  ////////////////////////////////////////////////////////////////////////
  // Engines answer two cycles after a request; sampled mid-cycle, no race
  always @(negedge REF_CLK) begin
    keys <= keys + 32'(KEY_VALID === 1'b1);
    writes <= writes + 32'(FLASH_WRITE === 1'b1);
    clr <= clr + 32'(KEY_CLEAR === 1'b1);
    if (KEY_VALID === 1'b1) kd <= 8'(kd + KEY_DATA);
  end
  // Hash engine kept apart, so the counters above see every edge
  always @(negedge REF_CLK) begin
    if (HASH_START === 1'b1) begin
      @(negedge REF_CLK);
      HASH_DONE = 1'b1;
      @(negedge REF_CLK);
      HASH_DONE = 1'b0;
    end
  end
  always @(negedge REF_CLK) begin
    if (FLASH_WRITE === 1'b1) begin
      @(negedge REF_CLK);
      FLASH_DONE = 1'b1;
      @(negedge REF_CLK);
      FLASH_DONE = 1'b0;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle;
    LIFECYCLE_STATE = 4'h1;
    ENC_WRITE_PENDING = 1'b0;
    AUTH_LEVEL = 2'h2;
    LOCK_STATUS = 4'h0;
    HASH_DONE = 1'b0;
    HASH_FAIL = 1'b0;
    TSS_ABNORMAL = 1'b0;
    FLASH_DONE = 1'b0;
    FLASH_FAIL = 1'b0;
    FLASH_STATUS = 32'h00000000;
  endtask

  // Junk byte first, then start, body, zero-sum checksum and end byte
  task automatic frame(input logic [7:0] st, input logic [7:0] f[$], input int bad);
    logic [7:0] s;
    s = 8'h00;
    foreach (f[i]) s = s - f[i];
    f.push_front(st);
    f.push_front(8'h55);
    f.push_back(s + 8'(bad == 1));
    f.push_back((bad == 2) ? 8'h00 : 8'h03);
    rkh_host_model_i.send(f);
  endtask

  task automatic cmd(input logic [7:0] key_identifier, input logic [7:0] permanent_lock_field, input int bad);
    logic [7:0] f[$];
    f = {8'h00, (bad == 3) ? 8'h04 : 8'h05, 8'h28, key_identifier, permanent_lock_field, 8'h00, 8'h02};
    if (bad == 3) f.pop_back();
    frame(8'h01, f, bad);
  endtask

  task automatic data(input logic [7:0] res, input int n);
    logic [7:0] f[$];
    f = {8'h00, 8'(n + 1), res};
    for (int i = 0; i < n; i++) f.push_back(8'(8'hA0 + i));
    frame(8'h81, f, 0);
  endtask

  task automatic reply(input logic [7:0] sts, input logic [31:0] det);
    logic [7:0] r[$];
    logic [7:0] s;
    int         t;
    r = {8'h00, 8'h0A, (sts == 8'h00) ? 8'h2E : 8'hAE, sts, det[31:24],
         det[23:16], det[15:8], det[7:0], 8'h0F, 8'hFF, 8'hFF, 8'hFF};
    s = 8'h00;
    foreach (r[i]) s = s - r[i];
    r.push_front(8'h81);
    r.push_back(s);
    r.push_back(8'h03);
    t = 0;
    while (rkh_host_model_i.rq.size() < 15 && t < 300) begin
      @(negedge REF_CLK);
      t++;
    end
    repeat (2) @(negedge REF_CLK);
    chk(32'(rkh_host_model_i.rq.size()), 15);
    foreach (r[i]) chk(rkh_host_model_i.rq[i], r[i]);
    rkh_host_model_i.rq.delete();
  endtask

  // Command, OK, then key data; status FFh means no reply may come
  task automatic flow(input logic [7:0] permanent_lock_field, input logic [7:0] res, input int n,
                      input logic [7:0] e, input logic [31:0] det);
    cmd(8'h02, permanent_lock_field, 0);
    reply(8'h00, NO_INFO);
    data(res, n);
    if (e === 8'hFF) begin
      repeat (60) @(negedge REF_CLK);
      chk(32'(rkh_host_model_i.rq.size()), 0);
    end
    else
      reply(e, det);
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Error table first, then full writes with engine faults
  initial begin
    logic [3:0] b, w, a;
    logic [7:0] key_identifier, permanent_lock_field, e;
    NRST = 1'b0;
    idle();
    repeat (3) @(negedge REF_CLK);
    NRST = 1'b1;
    foreach (ERR_TAB[i]) begin
      {b, LIFECYCLE_STATE, w, a, LOCK_STATUS, key_identifier, permanent_lock_field, e} = ERR_TAB[i];
      ENC_WRITE_PENDING = w[0];
      AUTH_LEVEL = a[1:0];
      cmd(key_identifier, permanent_lock_field, 32'(b));
      reply(e, NO_INFO);
    end
    idle();
    chk(writes, 0);
    flow(8'h00, 8'h2E, 2, 8'h00, NO_INFO);
    chk(keys, 2);
    chk(kd, 8'h41);
    chk(clr, 1);
    chk(writes, 1);
    chk(FLASH_LOCK, 1'b1);
    chk(FLASH_KEY_ID, 2'h2);
    flow(8'hFF, 8'h2E, 2, 8'h00, NO_INFO);
    chk(FLASH_LOCK, 1'b0);
    flow(8'hFF, 8'h2F, 2, 8'hC1, NO_INFO);
    flow(8'hFF, 8'h2E, 3, 8'hC5, NO_INFO);
    chk(writes, 2);
    rkh_host_model_i.slow = 1'b1;
    HASH_FAIL = 1'b1;
    flow(8'hFF, 8'h2E, 2, 8'hE4, NO_INFO);
    idle();
    FLASH_FAIL = 1'b1;
    FLASH_STATUS = 32'h00001234;
    flow(8'hFF, 8'h2E, 2, 8'hE1, 32'h00001234);
    idle();
    TSS_ABNORMAL = 1'b1;
    flow(8'hFF, 8'h2E, 2, 8'hFF, NO_INFO);
    chk(writes, 3);
    finish_test();
  end

  // Watchdog well beyond the thousand or so cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule
